// ===== rtl/tcdma_pkg.sv
package tcdma_pkg;

  // Channel count and low-priority relief
  localparam int TCDMA_NCH = 8;
  localparam logic [2:0] TCDMA_RELIEF_CH = 3'h6;
  localparam logic [1:0] TCDMA_RELIEF_LAST_BEAT = 2'h3;

  // Global register byte offsets
  localparam logic [11:0] OFF_IRQ_STAT = 12'h000;
  localparam logic [11:0] OFF_TC_CLR = 12'h004;
  localparam logic [11:0] OFF_ERR_CLR = 12'h008;
  localparam logic [11:0] OFF_ENABLED = 12'h00C;
  localparam logic [11:0] OFF_MASK = 12'h010;
  localparam logic [11:0] OFF_TEST_CTRL = 12'h014;
  localparam logic [11:0] OFF_TEST_OUT = 12'h018;
  localparam logic [11:0] OFF_TEST_IN = 12'h01C;
  localparam logic [11:0] OFF_TEST_ADDR = 12'h020;
  localparam logic [11:0] OFF_TEST_WDATA = 12'h024;
  localparam logic [11:0] OFF_TEST_RDATA = 12'h028;
  localparam logic [11:0] OFF_CH_BASE = 12'h100;
  localparam logic [11:0] OFF_CH_END = 12'h200;

  // Channel register word index within a 32-byte slot
  localparam logic [2:0] CH_SRC = 3'h0;
  localparam logic [2:0] CH_DST = 3'h1;
  localparam logic [2:0] CH_LLI = 3'h2;
  localparam logic [2:0] CH_CTL = 3'h3;
  localparam logic [2:0] CH_CFG = 3'h4;

  // Channel control word fields
  localparam int CTL_COUNT_W = 12;
  localparam int CTL_WIDTH_LSB = 12;
  localparam int CTL_PRIV_BIT = 14;
  localparam int CTL_BUF_BIT = 15;
  localparam int CTL_CACHE_BIT = 16;
  localparam int CTL_SWAP_BIT = 17;
  localparam int CTL_SINC_BIT = 18;
  localparam int CTL_DINC_BIT = 19;
  localparam int CTL_TCIE_BIT = 20;

  // Test output word fields
  localparam int TO_BUSREQ = 0;
  localparam int TO_HTRANS_LSB = 1;
  localparam int TO_HWRITE = 3;
  localparam int TO_HSIZE_LSB = 4;
  localparam int TO_HPROT_LSB = 7;
  localparam int TO_TC_LSB = 11;
  localparam int TO_ERR_LSB = 19;
  localparam int TO_ALL = 27;

  // Bus encodings
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_ERROR = 2'h1;
  localparam logic [3:0] HPROT_LLI = 4'hB;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [1:0] LLI_LAST = 2'h3;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_MASK = 16'h0000;

  // Transfer kinds
  localparam logic [1:0] OP_RD = 2'h0;
  localparam logic [1:0] OP_WR = 2'h1;
  localparam logic [1:0] OP_LLI = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ADDR = 4'h2,
    ST_DATA = 4'h4,
    ST_GAP = 4'h8
  } tcdma_state_t;

  // Address step for a programmed width
  function automatic logic [31:0] tcdma_step(input logic [1:0] w);
    tcdma_step = 32'h0000_0001 << w;
  endfunction

  // Byte-enable merge of a register write
  function automatic logic [31:0] tcdma_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] be);
    for (int i = 0; i < 4; i++)
    begin
      tcdma_merge[i*8 +: 8] = be[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
  endfunction

endpackage

// ===== rtl/tcdma_chan.sv
`timescale 1ns/10ps
module tcdma_chan
  import tcdma_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register writes
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] wr_be,
  // Engine events
  input wire logic rd_done,
  input wire logic [31:0] rd_data,
  input wire logic wr_done,
  input wire logic lli_ld,
  input wire logic [1:0] lli_idx,
  input wire logic [31:0] lli_data,
  input wire logic stop,
  // Channel state
  output logic [31:0] src,
  output logic [31:0] dst,
  output logic [31:0] linked_list_item,
  output logic [31:0] ctl,
  output logic en,
  output logic [31:0] buf_data,
  output logic buf_full,
  output logic req
);
  import tcdma_pkg::*;

  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] linked_list_item;
    logic [31:0] ctl;
    logic en;
    logic [31:0] bdata;
    logic full;
  } tcdma_ch_t;

  tcdma_ch_t s_reg;
  tcdma_ch_t s_next;

  always_comb
  begin
    s_next = s_reg;
    if (wr_en)
    begin
      if (wr_idx == CH_SRC)
        s_next.src = tcdma_merge(s_reg.src, wr_data, wr_be);
      else if (wr_idx == CH_DST)
        s_next.dst = tcdma_merge(s_reg.dst, wr_data, wr_be);
      else if (wr_idx == CH_LLI)
        s_next.linked_list_item = tcdma_merge(s_reg.linked_list_item, wr_data, wr_be);
      else if (wr_idx == CH_CTL)
        s_next.ctl = tcdma_merge(s_reg.ctl, wr_data, wr_be);
      else if (wr_idx == CH_CFG && wr_be[0])
        s_next.en = wr_data[0];
    end
    // Own holding word per channel
    if (rd_done)
    begin
      s_next.bdata = rd_data;
      s_next.full = 1'b1;
      if (s_reg.ctl[CTL_SINC_BIT])
        s_next.src = s_reg.src + tcdma_step(s_reg.ctl[CTL_WIDTH_LSB +: 2]);
    end
    if (wr_done)
    begin
      s_next.full = 1'b0;
      if (s_reg.ctl[CTL_DINC_BIT])
        s_next.dst = s_reg.dst + tcdma_step(s_reg.ctl[CTL_WIDTH_LSB +: 2]);
      s_next.ctl[CTL_COUNT_W-1:0] = s_reg.ctl[CTL_COUNT_W-1:0] - 12'h001;
      if (s_reg.ctl[CTL_COUNT_W-1:0] == 12'h001 && s_reg.linked_list_item == RST_WORD)
        s_next.en = 1'b0;
    end
    if (lli_ld)
    begin
      case (lli_idx)
        2'h0: s_next.src = lli_data;
        2'h1: s_next.dst = lli_data;
        2'h2: s_next.linked_list_item = {lli_data[31:2], 2'h0};
        default: s_next.ctl = lli_data;
      endcase
    end
    // Bus error stops the channel at the faulting transfer and drops its held word
    if (stop)
    begin
      s_next.en = 1'b0;
      s_next.full = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign src = s_reg.src;
  assign dst = s_reg.dst;
  assign linked_list_item = s_reg.linked_list_item;
  assign ctl = s_reg.ctl;
  assign en = s_reg.en;
  assign buf_data = s_reg.bdata;
  assign buf_full = s_reg.full;
  assign req = s_reg.en & (s_reg.full |
               (s_reg.ctl[CTL_COUNT_W-1:0] != 12'h000) |
               (s_reg.linked_list_item != RST_WORD));

endmodule // tcdma_chan

// ===== rtl/tcdma_top.sv
`timescale 1ns/10ps
module tcdma_top
  import tcdma_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register bus
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // System bus master
  output logic hbusreq,
  input wire logic hgrant,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [3:0] hprot,
  output logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hready,
  input wire logic [1:0] hresp,
  // Interrupts
  output logic [7:0] terminal_count_irq,
  output logic [7:0] error_irq,
  output logic combined_irq
);
  import tcdma_pkg::*;

  typedef struct packed {
    tcdma_state_t state;
    logic [1:0] op;
    logic [2:0] ch;
    logic [1:0] beat;
    logic [1:0] lidx;
    logic waitreq;
    logic [31:0] rdata;
    logic test_en;
    logic [31:0] test_out;
    logic [31:0] test_addr;
    logic [31:0] test_wdata;
    logic [7:0] tc_st;
    logic [7:0] err_st;
    logic [15:0] mask;
    logic busreq;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [3:0] hprot;
    logic [31:0] hwdata;
    logic [7:0] irq_tc;
    logic [7:0] irq_err;
    logic irq_all;
  } tcdma_top_t;

  tcdma_top_t s_reg;
  tcdma_top_t s_next;

  logic [31:0] ch_src [TCDMA_NCH];
  logic [31:0] ch_dst [TCDMA_NCH];
  logic [31:0] ch_lli [TCDMA_NCH];
  logic [31:0] ch_ctl [TCDMA_NCH];
  logic [31:0] ch_buf [TCDMA_NCH];
  logic [7:0] ch_en;
  logic [7:0] ch_full;
  logic [7:0] ch_req;
  logic [7:0] cmd_wr;
  logic [7:0] cmd_rd_done;
  logic [7:0] cmd_wr_done;
  logic [7:0] cmd_lli;
  logic [7:0] cmd_stop;
  logic [31:0] cmd_rdata;

  // Lowest index wins
  function automatic logic [2:0] pick(input logic [7:0] r);
    pick = 3'h0;
    for (int i = TCDMA_NCH - 1; i >= 0; i--)
    begin
      if (r[i])
        pick = 3'(i);
    end
  endfunction

  // Selects the addressed lane of read data
  function automatic logic [31:0] lane_get(input logic [31:0] d,
                                           input logic [1:0] a,
                                           input logic [1:0] w);
    logic [31:0] sh;
    sh = d >> {a, 3'h0};
    if (w == 2'h0)
      lane_get = {24'h000000, sh[7:0]};
    else if (w == 2'h1)
      lane_get = {16'h0000, sh[15:0]};
    else
      lane_get = d;
  endfunction

  // Write data formatting
  function automatic logic [31:0] wr_fmt(input logic [31:0] d,
                                         input logic [1:0] w,
                                         input logic swap);
    if (w == 2'h0)
      wr_fmt = {4{d[7:0]}};
    else if (w == 2'h1)
      wr_fmt = {2{d[15:0]}};
    else if (swap)
      wr_fmt = {d[7:0], d[15:8], d[23:16], d[31:24]};
    else
      wr_fmt = d;
  endfunction

  // Dedicated channels
  for (genvar g = 0; g < TCDMA_NCH; g++)
  begin : g_ch
    tcdma_chan u_chan (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .wr_en(cmd_wr[g]),
      .wr_idx(avs_address[4:2]),
      .wr_data(avs_writedata),
      .wr_be(avs_byteenable),
      .rd_done(cmd_rd_done[g]),
      .rd_data(cmd_rdata),
      .wr_done(cmd_wr_done[g]),
      .lli_ld(cmd_lli[g]),
      .lli_idx(s_reg.lidx),
      .lli_data(hrdata),
      .stop(cmd_stop[g]),
      .src(ch_src[g]),
      .dst(ch_dst[g]),
      .linked_list_item(ch_lli[g]),
      .ctl(ch_ctl[g]),
      .en(ch_en[g]),
      .buf_data(ch_buf[g]),
      .buf_full(ch_full[g]),
      .req(ch_req[g])
    );
  end

  always_comb
  begin
    logic acc;
    logic [7:0] tc_set;
    logic [7:0] err_set;
    logic [7:0] tc_clr;
    logic [7:0] err_clr;
    logic [31:0] c;
    logic [31:0] rd_mux;
    logic [2:0] ci;
    s_next = s_reg;
    acc = avs_read | avs_write;
    tc_set = 8'h00;
    err_set = 8'h00;
    tc_clr = 8'h00;
    err_clr = 8'h00;
    cmd_wr = 8'h00;
    cmd_rd_done = 8'h00;
    cmd_wr_done = 8'h00;
    cmd_lli = 8'h00;
    cmd_stop = 8'h00;
    cmd_rdata = RST_WORD;
    ci = s_reg.ch;
    c = ch_ctl[ci];
    rd_mux = RST_WORD;

    // Transfer engine; one channel at a time on the single clock
    case (s_reg.state)
      ST_IDLE:
      begin
        s_next.busreq = |ch_req;
        if (!s_reg.test_en && ch_req != 8'h00)
        begin
          s_next.ch = pick(ch_req);
          if (ch_full[s_next.ch])
            s_next.op = OP_WR;
          else if (ch_ctl[s_next.ch][CTL_COUNT_W-1:0] != 12'h000)
            s_next.op = OP_RD;
          else
            s_next.op = OP_LLI;
          s_next.lidx = 2'h0;
          s_next.state = ST_ADDR;
        end
      end
      ST_ADDR:
      begin
        if (hgrant && hready)
        begin
          s_next.htrans = HTRANS_IDLE;
          s_next.state = ST_DATA;
        end
      end
      ST_DATA:
      begin
        if (hready && hresp == HRESP_ERROR)
        begin
          cmd_stop[ci] = 1'b1;
          err_set[ci] = 1'b1;
          s_next.state = ST_IDLE;
        end
        else if (hready)
        begin
          if (s_reg.op == OP_RD)
          begin
            cmd_rd_done[ci] = 1'b1;
            cmd_rdata = lane_get(hrdata, s_reg.haddr[1:0],
                                 c[CTL_WIDTH_LSB +: 2]);
            // Delegated pair completes before any switch
            s_next.op = OP_WR;
            s_next.state = ST_ADDR;
          end
          else if (s_reg.op == OP_WR)
          begin
            cmd_wr_done[ci] = 1'b1;
            if (c[CTL_COUNT_W-1:0] == 12'h001 && ch_lli[ci] == RST_WORD &&
                c[CTL_TCIE_BIT])
              tc_set[ci] = 1'b1;
            s_next.beat = (ci >= TCDMA_RELIEF_CH) ? s_reg.beat + 2'h1 :
                          2'h0;
            if (ci >= TCDMA_RELIEF_CH && s_reg.beat == TCDMA_RELIEF_LAST_BEAT)
            begin
              s_next.busreq = 1'b0;
              s_next.beat = 2'h0;
              s_next.state = ST_GAP;
            end
            else
              s_next.state = ST_IDLE;
          end
          else
          begin
            cmd_lli[ci] = 1'b1;
            s_next.lidx = s_reg.lidx + 2'h1;
            if (s_reg.lidx == LLI_LAST)
              s_next.state = ST_IDLE;
            else
              s_next.state = ST_ADDR;
          end
        end
      end
      ST_GAP:
      begin
        s_next.busreq = 1'b0;
        s_next.state = ST_IDLE;
      end
      default:
        s_next.state = ST_IDLE;
    endcase

    // Address phase setup on entry
    if (s_next.state == ST_ADDR && s_reg.state != ST_ADDR)
    begin
      s_next.busreq = 1'b1;
      s_next.htrans = HTRANS_NONSEQ;
      if (s_next.op == OP_LLI)
      begin
        s_next.haddr = ch_lli[s_next.ch] + {28'h0000000, s_next.lidx, 2'h0};
        s_next.hwrite = 1'b0;
        s_next.hsize = HSIZE_WORD;
        s_next.hprot = HPROT_LLI;
      end
      else
      begin
        c = ch_ctl[s_next.ch];
        s_next.hsize = {1'b0, c[CTL_WIDTH_LSB +: 2]};
        s_next.hprot = {c[CTL_CACHE_BIT], c[CTL_BUF_BIT],
                        c[CTL_PRIV_BIT], 1'b1};
        if (s_next.op == OP_WR)
        begin
          s_next.haddr = ch_dst[s_next.ch];
          s_next.hwrite = 1'b1;
          s_next.hwdata = wr_fmt(s_reg.op == OP_RD ? cmd_rdata :
                                 ch_buf[s_next.ch], c[CTL_WIDTH_LSB +: 2],
                                 c[CTL_SWAP_BIT]);
        end
        else
        begin
          s_next.haddr = ch_src[s_next.ch];
          s_next.hwrite = 1'b0;
        end
      end
    end

    // Register bus slave: one wait cycle per access
    s_next.waitreq = !(acc && s_reg.waitreq);
    if (acc && s_reg.waitreq)
    begin
      if (avs_address == OFF_IRQ_STAT)
        rd_mux = {16'h0000, s_reg.err_st, s_reg.tc_st};
      else if (avs_address == OFF_ENABLED)
        rd_mux = {24'h000000, ch_en};
      else if (avs_address == OFF_MASK)
        rd_mux = {16'h0000, s_reg.mask};
      else if (avs_address == OFF_TEST_CTRL)
        rd_mux = {31'h00000000, s_reg.test_en};
      else if (avs_address == OFF_TEST_OUT)
        rd_mux = s_reg.test_out;
      else if (avs_address == OFF_TEST_IN)
        rd_mux = {28'h0000000, hresp, hready, hgrant};
      else if (avs_address == OFF_TEST_ADDR)
        rd_mux = s_reg.test_addr;
      else if (avs_address == OFF_TEST_WDATA)
        rd_mux = s_reg.test_wdata;
      else if (avs_address == OFF_TEST_RDATA)
        rd_mux = hrdata;
      else if (avs_address >= OFF_CH_BASE && avs_address < OFF_CH_END)
      begin
        ci = avs_address[7:5];
        if (avs_address[4:2] == CH_SRC)
          rd_mux = ch_src[ci];
        else if (avs_address[4:2] == CH_DST)
          rd_mux = ch_dst[ci];
        else if (avs_address[4:2] == CH_LLI)
          rd_mux = ch_lli[ci];
        else if (avs_address[4:2] == CH_CTL)
          rd_mux = ch_ctl[ci];
        else if (avs_address[4:2] == CH_CFG)
          rd_mux = {31'h00000000, ch_en[ci]};
      end
      s_next.rdata = avs_read ? rd_mux : RST_WORD;
    end
    if (avs_write && !s_reg.waitreq)
    begin
      if (avs_address == OFF_TC_CLR)
        tc_clr = avs_writedata[7:0];
      else if (avs_address == OFF_ERR_CLR)
        err_clr = avs_writedata[7:0];
      else if (avs_address == OFF_MASK)
        s_next.mask = 16'(tcdma_merge({16'h0000, s_reg.mask},
                                      avs_writedata, avs_byteenable));
      else if (avs_address == OFF_TEST_CTRL && avs_byteenable[0])
        s_next.test_en = avs_writedata[0];
      else if (avs_address == OFF_TEST_OUT)
        s_next.test_out = tcdma_merge(s_reg.test_out, avs_writedata,
                                      avs_byteenable);
      else if (avs_address == OFF_TEST_ADDR)
        s_next.test_addr = tcdma_merge(s_reg.test_addr, avs_writedata,
                                       avs_byteenable);
      else if (avs_address == OFF_TEST_WDATA)
        s_next.test_wdata = tcdma_merge(s_reg.test_wdata, avs_writedata,
                                        avs_byteenable);
      else if (avs_address >= OFF_CH_BASE && avs_address < OFF_CH_END)
        cmd_wr[avs_address[7:5]] = 1'b1;
    end

    // Sticky status: a set in the clearing cycle wins
    s_next.tc_st = (s_reg.tc_st & ~tc_clr) | tc_set;
    s_next.err_st = (s_reg.err_st & ~err_clr) | err_set;
    s_next.irq_tc = s_next.tc_st & s_next.mask[7:0];
    s_next.irq_err = s_next.err_st & s_next.mask[15:8];
    s_next.irq_all = |{s_next.irq_tc, s_next.irq_err};

    // Integration test drives every bus master and interrupt output
    if (s_next.test_en)
    begin
      s_next.state = ST_IDLE;
      s_next.busreq = s_next.test_out[TO_BUSREQ];
      s_next.htrans = s_next.test_out[TO_HTRANS_LSB +: 2];
      s_next.hwrite = s_next.test_out[TO_HWRITE];
      s_next.hsize = s_next.test_out[TO_HSIZE_LSB +: 3];
      s_next.hprot = s_next.test_out[TO_HPROT_LSB +: 4];
      s_next.haddr = s_next.test_addr;
      s_next.hwdata = s_next.test_wdata;
      s_next.irq_tc = s_next.test_out[TO_TC_LSB +: 8];
      s_next.irq_err = s_next.test_out[TO_ERR_LSB +: 8];
      s_next.irq_all = s_next.test_out[TO_ALL];
    end
    else if (s_reg.test_en)
    begin
      s_next.busreq = 1'b0;
      s_next.htrans = HTRANS_IDLE;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_reg <= '0;
      s_reg.state <= ST_IDLE;
      s_reg.waitreq <= 1'b1;
      s_reg.mask <= RST_MASK;
      s_reg.hprot <= HPROT_LLI;
      s_reg.hsize <= HSIZE_WORD;
    end
    else
      s_reg <= s_next;
  end

  assign avs_readdata = s_reg.rdata;
  assign avs_waitrequest = s_reg.waitreq;
  assign hbusreq = s_reg.busreq;
  assign haddr = s_reg.haddr;
  assign htrans = s_reg.htrans;
  assign hwrite = s_reg.hwrite;
  assign hsize = s_reg.hsize;
  assign hprot = s_reg.hprot;
  assign hwdata = s_reg.hwdata;
  assign terminal_count_irq = s_reg.irq_tc;
  assign error_irq = s_reg.irq_err;
  assign combined_irq = s_reg.irq_all;

endmodule // tcdma_top

// ===== dv/tcdma_ahb_model.sv
`timescale 1ns/10ps
module tcdma_ahb_model
  import tcdma_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Master side
  input wire logic hbusreq,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  // Slave and arbiter answers
  output logic hgrant,
  output logic [31:0] hrdata,
  output logic hready,
  output logic [1:0] hresp,
  // Scenario controls
  input wire logic [31:0] err_addr,
  input wire logic slow
);
  logic [31:0] mem [64];
  logic ph, pw, pe;
  logic [1:0] cnt;
  logic [5:0] pa;
  assign hready = !ph || cnt == 2'h0;
  // Two-cycle error answer on a faulting transfer
  assign hresp = (ph && pe) ? HRESP_ERROR : 2'h0;
  assign hrdata = (ph && !pw) ? mem[pa] : ~mem[pa];
  always @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      hgrant <= 1'b0;
      ph <= 1'b0;
      cnt <= 2'h0;
    end
    else
    begin
      hgrant <= hbusreq;
      if (ph && hready && pw && !pe)
        mem[pa] <= hwdata;
      if (ph && hready)
        ph <= 1'b0;
      else if (ph)
        cnt <= cnt - 2'h1;
      if (htrans == HTRANS_NONSEQ && hgrant && hready)
      begin
        ph <= 1'b1;
        pa <= haddr[7:2];
        pw <= hwrite;
        pe <= haddr == err_addr;
        cnt <= (haddr == err_addr) ? 2'h1 : {slow, 1'b0};
      end
    end
endmodule // tcdma_ahb_model

// ===== dv/tcdma_chk.sv
`timescale 1ns/10ps
module tcdma_chk
  import tcdma_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // System bus
  input wire logic hbusreq,
  input wire logic hgrant,
  input wire logic hready,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic [3:0] hprot,
  // Interrupts
  input wire logic [7:0] terminal_count_irq,
  input wire logic [7:0] error_irq,
  input wire logic combined_irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic nsq;
  assign nsq = htrans == HTRANS_NONSEQ;
  a_prot_data: assert property (nsq |-> hprot[0])
    else $error("data bit low");
  a_irq_or: assert property (combined_irq == |{terminal_count_irq, error_irq})
    else $error("combined irq wrong");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("no answer");
  a_wait_back: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer too long");
  a_single_xfer: assert property (nsq && hgrant && hready |=> !nsq)
    else $error("transfer not single");
  a_addr_hold: assert property (nsq && !(hgrant && hready)
    |=> nsq && $stable(haddr) && $stable(hprot)) else $error("addr moved");
  a_req_held: assert property (nsq |-> hbusreq) else $error("no request");
  a_idle_hold: assert property (!nsq ##1 !nsq |-> $stable(haddr))
    else $error("idle addr moved");
  c_xfer: cover property (nsq && hgrant && hready);
  c_err: cover property ($rose(|error_irq));
  c_tc: cover property ($rose(|terminal_count_irq));
endmodule // tcdma_chk
bind tcdma_top tcdma_chk i_tcdma_chk (.mclk, .sys_rst, .avs_read, .avs_write,
  .avs_waitrequest, .hbusreq, .hgrant, .hready, .haddr, .htrans, .hprot,
  .terminal_count_irq, .error_irq, .combined_irq);

// ===== dv/tb_tcdma_top.sv
`timescale 1ns/10ps
module tb_tcdma_top;
  import tcdma_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, haddr, hwdata, hrdata, q;
  logic [31:0] err_addr = 32'hFFFF_FFFF;
  logic avs_waitrequest, hbusreq, hgrant, hwrite, hready, combined_irq;
  logic slow = 1'b0, req_q = 1'b0;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize;
  logic [3:0] hprot, exp_prot = 4'h1;
  logic [7:0] terminal_count_irq, error_irq;
  int err_total = 0, samples_checked = 0, falls = 0;
  logic [1:0] wlog [$];
  always #2 mclk = ~mclk;
  tcdma_top i_tcdma_top (.mclk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
    .hbusreq, .hgrant, .haddr, .htrans, .hwrite, .hsize, .hprot, .hwdata,
    .hrdata, .hready, .hresp, .terminal_count_irq, .error_irq, .combined_irq);
  tcdma_ahb_model i_tcdma_ahb_model (.mclk, .sys_rst, .hbusreq, .haddr,
    .htrans, .hwrite, .hwdata, .hgrant, .hrdata, .hready, .hresp, .err_addr,
    .slow);
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0)
    begin
      err_total++;
      close_out();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic prog(input int ch, input logic [31:0] s, d, l, c);
    logic [11:0] b;
    b = OFF_CH_BASE + 12'(ch * 32);
    bus(1'b1, b, s);
    bus(1'b1, b + 12'h4, d);
    bus(1'b1, b + 12'h8, l);
    bus(1'b1, b + 12'hC, c);
  endtask
  task automatic en(input int ch);
    bus(1'b1, OFF_CH_BASE + 12'(ch * 32) + 12'h10, 32'h1);
  endtask
  task automatic wait_off(input int ch);
    int n;
    n = 0;
    do
    begin
      bus(1'b0, OFF_ENABLED, 32'h0);
      n++;
    end
    while (q[ch] !== 1'b0 && n < 300);
    if (q[ch] !== 1'b0)
    begin
      err_total++;
      close_out();
    end
  endtask
  // Prot attributes of every accepted address phase, and the write order
  always @(posedge mclk)
  begin
    req_q <= hbusreq;
    if (req_q === 1'b1 && hbusreq === 1'b0)
      falls++;
    if (htrans === HTRANS_NONSEQ && hgrant === 1'b1 && hready === 1'b1)
    begin
      if (!hwrite && haddr[7:4] === 4'hF)
        chk(32'(hprot), 32'(HPROT_LLI));
      else
        chk(32'(hprot), 32'(exp_prot));
      chk(32'(hsize), 32'(HSIZE_WORD));
      if (hwrite)
        wlog.push_back(haddr[7:6]);
    end
  end
  task automatic s_test();
    bus(1'b1, OFF_TEST_CTRL, 32'h1);
    bus(1'b1, OFF_TEST_OUT, 32'h1);
    bus(1'b0, OFF_TEST_IN, 32'h0);
    chk(hbusreq, 1'b1);
    bus(1'b0, OFF_TEST_IN, 32'h0);
    chk(q[0], 1'b1);
    bus(1'b1, OFF_TEST_OUT, 32'h0);
    bus(1'b1, OFF_TEST_CTRL, 32'h0);
  endtask
  task automatic s_swap();
    exp_prot = 4'h5;
    prog(1, 32'h0, 32'h10, 32'h0, 32'h0002_A001);
    en(1);
    wait_off(1);
    chk(i_tcdma_ahb_model.mem[4], 32'h0000_00A0);
  endtask
  task automatic s_copy(input int ch, input int d, input int nf);
    falls = 0;
    exp_prot = 4'hD;
    prog(ch, 32'h0, 32'(d), 32'h0, 32'h001D_A006);
    en(ch);
    wait_off(ch);
    for (int i = 0; i < 6; i++)
      chk(i_tcdma_ahb_model.mem[d / 4 + i], 32'hA000_0000 + 32'(i));
    chk(falls, nf);
    chk(terminal_count_irq[ch], 1'b1);
    chk(combined_irq, 1'b1);
    bus(1'b1, OFF_TC_CLR, 32'hFF);
    bus(1'b0, OFF_IRQ_STAT, 32'h0);
    chk(q, 32'h0);
  endtask
  task automatic s_prio();
    int last, n5;
    last = 0;
    n5 = 0;
    prog(2, 32'h0, 32'hC0, 32'h0, 32'h000D_A004);
    prog(5, 32'h0, 32'h80, 32'h0, 32'h000D_A004);
    wlog.delete();
    en(5);
    en(2);
    wait_off(5);
    foreach (wlog[i])
      if (wlog[i] === 2'h3)
        last = i;
    for (int i = 0; i < last; i++)
      if (wlog[i] === 2'h2)
        n5++;
    chk(n5 <= 1, 1'b1);
    chk(wlog.size(), 8);
  endtask
  task automatic s_err();
    for (int i = 48; i < 52; i++)
      i_tcdma_ahb_model.mem[i] = 32'h0;
    exp_prot = 4'h1;
    err_addr <= 32'h4;
    prog(4, 32'h0, 32'hC0, 32'h0, 32'h000C_2004);
    en(4);
    wait_off(4);
    chk(error_irq[4], 1'b1);
    chk(combined_irq, 1'b1);
    chk(i_tcdma_ahb_model.mem[48], 32'hA000_0000);
    chk(i_tcdma_ahb_model.mem[50], 32'h0);
    err_addr <= 32'hFFFF_FFFF;
    bus(1'b1, OFF_ERR_CLR, 32'hFF);
    chk(error_irq, 8'h0);
  endtask
  task automatic s_lli();
    i_tcdma_ahb_model.mem[60] = 32'h8;
    i_tcdma_ahb_model.mem[61] = 32'h20;
    i_tcdma_ahb_model.mem[62] = 32'h0;
    i_tcdma_ahb_model.mem[63] = 32'h000C_6002;
    exp_prot = 4'h3;
    slow <= 1'b1;
    prog(6, 32'h0, 32'h30, 32'hF0, 32'h000C_6001);
    en(6);
    wait_off(6);
    chk(i_tcdma_ahb_model.mem[12], 32'hA000_0000);
    chk(i_tcdma_ahb_model.mem[8], 32'hA000_0002);
    chk(i_tcdma_ahb_model.mem[9], 32'hA000_0003);
  endtask
  initial
  begin
    for (int i = 0; i < 64; i++)
      i_tcdma_ahb_model.mem[i] = 32'hA000_0000 + 32'(i);
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    bus(1'b0, OFF_MASK, 32'h0);
    chk(q, {16'h0, RST_MASK});
    bus(1'b0, 12'h0FC, 32'h0);
    chk(q, 32'h0);
    s_test();
    bus(1'b1, OFF_MASK, 32'h0000_FFFF);
    s_copy(0, 32'h80, 1);
    s_copy(7, 32'h40, 2);
    s_prio();
    s_err();
    s_swap();
    s_lli();
    close_out();
  end
  initial
  begin
    #200000;
    err_total++;
    close_out();
  end
endmodule // tb_tcdma_top
